// >>> inc/cd_ctrl_pkg.sv
// Constants shared by the decoder control register bank.
// Assumes a 32-bit APB slave with each register in one aligned word.
package cd_ctrl_pkg;

  localparam int IDX_W  = 6;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NIB_W  = 4;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_PLL_EQ  = 6'h09;
  localparam logic [IDX_W-1:0] IDX_DAO     = 6'h0A;
  localparam logic [IDX_W-1:0] IDX_SPEED   = 6'h0B;
  localparam logic [IDX_W-1:0] IDX_MUTE    = 6'h0C;
  localparam logic [IDX_W-1:0] IDX_PINS    = 6'h0D;
  localparam logic [IDX_W-1:0] IDX_AUDIO   = 6'h0E;
  localparam logic [IDX_W-1:0] IDX_SUBCODE = 6'h0F;
  localparam logic [IDX_W-1:0] IDX_STATUS  = 6'h10;
  localparam logic [IDX_W-1:0] IDX_EXIT    = 6'h11;
  localparam int REG_FIRST = 9;
  localparam int REG_LAST  = 15;

  // Equalization codes
  localparam logic [3:0] EQ_OVER30  = 4'h1;
  localparam logic [3:0] EQ_OVER15  = 4'h2;
  localparam logic [3:0] EQ_NOMINAL = 4'h3;
  localparam logic [3:0] EQ_UNDER15 = 4'h4;
  localparam logic [3:0] EQ_UNDER30 = 4'h5;

  // Reset values
  localparam logic [3:0] RST_PLL_EQ  = 4'h3;
  localparam logic [3:0] RST_DAO     = 4'h2;
  localparam logic [3:0] RST_SPEED   = 4'h0;
  localparam logic [3:0] RST_MUTE    = 4'h2;
  localparam logic [3:0] RST_PINS    = 4'hF;
  localparam logic [3:0] RST_AUDIO   = 4'h4;
  localparam logic [3:0] RST_SUBCODE = 4'h0;

  // Field positions
  localparam int DAO_ACC_LO   = 0;
  localparam int DAO_AFTER    = 1;
  localparam int DAO_ACC_HI   = 2;
  localparam int DAO_FLAGS    = 3;
  localparam int SPD_CRYSTAL  = 2;
  localparam int SPD_DOUBLE   = 3;
  localparam int MUTE_OFFTRK  = 0;
  localparam int MUTE_SINGLE  = 1;
  localparam int MUTE_PIN3    = 2;
  localparam int AUD_BRAKE    = 0;
  localparam int AUD_LOCK     = 1;
  localparam int AUD_FEATURE  = 2;
  localparam int SUB_SHADOW   = 0;
  localparam int SUB_ON       = 2;
  localparam int SUB_THREE    = 3;
  localparam int STAT_SHADOW  = 0;
  localparam int STAT_PIN1    = 1;
  localparam int STAT_OP_LO   = 2;
  localparam int STAT_OFFTRK  = 4;
  localparam int EXIT_BIT     = 0;

  // Versatile pin four/five field codes
  localparam logic [1:0] PIN_MOTOR = 2'h0;
  localparam logic [1:0] PIN_ALT   = 2'h1;
  localparam logic [1:0] PIN_LOW   = 2'h2;
  localparam logic [1:0] PIN_HIGH  = 2'h3;

  typedef enum logic [1:0] {
    OP_STOP_STANDBY  = 2'h0,
    OP_PAUSE_STANDBY = 2'h2,
    OP_RUNNING       = 2'h3
  } op_state_type;

  function automatic logic [3:0] reset_of(input logic [IDX_W-1:0] idx);
    logic [3:0] v;
    v = 4'h0;
    case (idx)
      IDX_PLL_EQ:  v = RST_PLL_EQ;
      IDX_DAO:     v = RST_DAO;
      IDX_SPEED:   v = RST_SPEED;
      IDX_MUTE:    v = RST_MUTE;
      IDX_PINS:    v = RST_PINS;
      IDX_AUDIO:   v = RST_AUDIO;
      IDX_SUBCODE: v = RST_SUBCODE;
      default:     v = 4'h0;
    endcase
    return v;
  endfunction

  // Undocumented codes are refused rather than stored while shadow mode is off
  function automatic logic code_ok(input logic [IDX_W-1:0] idx,
                                   input logic [3:0] d);
    logic ok;
    ok = 1'b1;
    case (idx)
      IDX_PLL_EQ: ok = (d == EQ_OVER30) || (d == EQ_OVER15) ||
                       (d == EQ_NOMINAL) || (d == EQ_UNDER15) ||
                       (d == EQ_UNDER30);
      IDX_SPEED:  ok = (d[1:0] != 2'h1);
      IDX_MUTE:   ok = !d[MUTE_SINGLE] || !d[3];
      IDX_PINS:   ok = ((d[1:0] == PIN_MOTOR) == (d[3:2] == PIN_MOTOR));
      IDX_AUDIO:  ok = !d[3];
      default:    ok = 1'b1;
    endcase
    return ok;
  endfunction

endpackage

// >>> design/sync_two_ff.sv
// Two-stage synchroniser for levels arriving from outside the clock domain.
// Assumes the caller reads only dout.
`timescale 1ns/1ps
`default_nettype none
module sync_two_ff #(
  parameter int W = 1
) (
  // Clock, reset, enable
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  // Data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      dout     <= '0;
    end else if (clk_en) begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// >>> design/reset_release.sv
// Reset conditioner: asserts at once, releases after two clock edges.
// Assumes nrst may change at any time relative to clock.
`timescale 1ns/1ps
`default_nettype none
module reset_release (
  // Clock and raw reset
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic clk_en,
  // Conditioned reset
  output logic      rst_n_sync
);
  logic stage_reg;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stage_reg  <= 1'b0;
      rst_n_sync <= 1'b0;
    end else if (clk_en) begin
      stage_reg  <= 1'b1;
      rst_n_sync <= stage_reg;
    end
  end
endmodule
`default_nettype wire

// >>> design/cd_decoder_control_regs.sv
// Decoder control register bank (equalization, digital audio output,
// speed/standby, versatile pins, audio features, subcode, shadow bank).
// Assumes an APB master on clock; pin one is asynchronous, other inputs
// come from logic on the same clock.
//
// Contract
// - Equalization register at index 9 resets to the nominal code 0011.
// - Equalization codes 0001, 0010, 0100, 0101 select over/under equalization.
// - Audio output bit 1 picks data before or after concealment; reset 1.
// - Bits 2 and 0 give accuracy level; both set turns output off low.
// - Speed bit 2 low for the fast crystal or PLL clock select high.
// - Speed bit 2 high when the mid crystal drives directly.
// - Speed bits 1:0 give stop standby, pause standby or running.
// - Mute bit 0 takes off-track from pin one, else internal signal.
// - Mute bits set separate flags or single kill with fixed pin three.
// - Pin register zero makes pins four and five a motor interface.
// - Pin four shows subcode, low or high; reset high.
// - Pin five shows de-emphasis with filter bypass, low or high.
// - Audio feature field 01 enables, 00 disables; reset enabled.
// - Lock-to-disc bit on when set; reset off.
// - Subcode interface bit switches it on; reset off.
// - Shadow bit redirects later writes to indices 9 to 15 to the shadow set.
// - Every field takes its marked initial value at reset.
`timescale 1ns/1ps
`default_nettype none
module cd_decoder_control_regs (
  // Clock, reset, enable
  input  wire logic                           clock,
  input  wire logic                           nrst,
  input  wire logic                           clk_en,
  // APB slave
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [cd_ctrl_pkg::ADDR_W-1:0] paddr,
  input  wire logic [cd_ctrl_pkg::DATA_W-1:0] pwdata,
  output logic      [cd_ctrl_pkg::DATA_W-1:0] prdata,
  output logic                                pready,
  output logic                                pslverr,
  // Decoder-side inputs
  input  wire logic                           versatile_pin_one,
  input  wire logic                           internal_offtrack,
  input  wire logic                           kill_left,
  input  wire logic                           kill_right,
  input  wire logic                           subcode_q_to_w,
  input  wire logic                           deemph_flag,
  input  wire logic                           motor_line_a,
  input  wire logic                           motor_line_b,
  // Configuration outputs
  output logic      [3:0]                     pll_eq_code,
  output logic                                dao_after_conceal,
  output logic      [1:0]                     dao_accuracy,
  output logic                                dao_off,
  output logic                                dao_flags_on,
  output logic                                crystal_direct,
  output logic                                double_speed,
  output logic      [1:0]                     op_state,
  output logic                                offtrack_external,
  output logic                                separate_mute,
  output logic                                motor_four_line,
  output logic                                deemph_bypass,
  output logic                                audio_features_en,
  output logic                                lock_to_disc,
  output logic                                brake_six_pct,
  output logic                                subcode_on,
  output logic                                subcode_three_wire,
  output logic                                shadow_bank_enable,
  // Pin outputs
  output logic                                offtrack_signal,
  output logic                                kill_out,
  output logic                                versatile_pin_three,
  output logic                                versatile_pin_four,
  output logic                                versatile_pin_five,
  // Shadow bank write port
  output logic                                shadow_wr_strobe,
  output logic      [3:0]                     shadow_wr_addr,
  output logic      [3:0]                     shadow_wr_data
);

  logic rst_n;
  logic pin1_sync;

  reset_release u_reset (
    .clock      (clock),
    .nrst       (nrst),
    .clk_en     (clk_en),
    .rst_n_sync (rst_n)
  );

  sync_two_ff #(.W(1)) u_pin1_sync (
    .clock  (clock),
    .rst_n  (rst_n),
    .clk_en (clk_en),
    .din    (versatile_pin_one),
    .dout   (pin1_sync)
  );

  // Register storage, indexed by the register index (address bits 7:2)
  logic [3:0] bank_reg [cd_ctrl_pkg::REG_FIRST:cd_ctrl_pkg::REG_LAST];
  logic       shadow_reg;
  logic       shadow_next;

  // Address decode
  wire logic [cd_ctrl_pkg::IDX_W-1:0] idx = paddr[cd_ctrl_pkg::ADDR_W-1:2];
  wire logic [3:0] nib     = pwdata[3:0];
  wire logic       aligned = (paddr[1:0] == 2'h0);
  wire logic       in_bank = aligned &&
                             (idx >= cd_ctrl_pkg::IDX_PLL_EQ) &&
                             (idx <= cd_ctrl_pkg::IDX_SUBCODE);
  wire logic       is_stat = aligned && (idx == cd_ctrl_pkg::IDX_STATUS);
  wire logic       is_exit = aligned && (idx == cd_ctrl_pkg::IDX_EXIT);
  wire logic       setup   = psel && !penable;
  wire logic       access  = psel && penable && pready;
  wire logic       to_shadow = shadow_reg && in_bank;
  wire logic       bad_code  = in_bank && !shadow_reg &&
                               !cd_ctrl_pkg::code_ok(idx, nib);
  wire logic       setup_err = !(in_bank || is_stat || is_exit) ||
                               (pwrite && (bad_code || is_stat));
  wire logic       wr_ok   = access && pwrite && !pslverr;
  wire logic       wr_main = wr_ok && in_bank && !shadow_reg;
  wire logic       wr_shad = wr_ok && to_shadow;
  wire logic       wr_exit = wr_ok && is_exit && pwdata[cd_ctrl_pkg::EXIT_BIT];

  // Main bank, one flop group per register
  genvar gi;
  generate
    for (gi = cd_ctrl_pkg::REG_FIRST; gi <= cd_ctrl_pkg::REG_LAST;
         gi = gi + 1) begin : g_bank
      localparam int GI = gi;
      localparam logic [cd_ctrl_pkg::IDX_W-1:0] GIDX =
        GI[cd_ctrl_pkg::IDX_W-1:0];
      // Reset value fixed at elaboration so the reset branch stays constant
      localparam logic [3:0] GRST = cd_ctrl_pkg::reset_of(GIDX);
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          bank_reg[gi] <= GRST;
        end else if (clk_en && wr_main && (idx == GIDX)) begin
          bank_reg[gi] <= nib;
        end
      end
    end
  endgenerate

  wire logic [3:0] eq_r  = bank_reg[cd_ctrl_pkg::IDX_PLL_EQ];
  wire logic [3:0] dao_r = bank_reg[cd_ctrl_pkg::IDX_DAO];
  wire logic [3:0] spd_r = bank_reg[cd_ctrl_pkg::IDX_SPEED];
  wire logic [3:0] mut_r = bank_reg[cd_ctrl_pkg::IDX_MUTE];
  wire logic [3:0] pin_r = bank_reg[cd_ctrl_pkg::IDX_PINS];
  wire logic [3:0] aud_r = bank_reg[cd_ctrl_pkg::IDX_AUDIO];
  wire logic [3:0] sub_r = bank_reg[cd_ctrl_pkg::IDX_SUBCODE];

  // Shadow bit: setting comes from the subcode register; only an exit
  // write clears it because shadow-mode writes never reach this bank
  wire logic sub_sets_shadow = wr_main &&
                               (idx == cd_ctrl_pkg::IDX_SUBCODE) &&
                               nib[cd_ctrl_pkg::SUB_SHADOW];
  wire logic sub_clr_shadow  = wr_main &&
                               (idx == cd_ctrl_pkg::IDX_SUBCODE) &&
                               !nib[cd_ctrl_pkg::SUB_SHADOW];
  assign shadow_next = sub_sets_shadow ? 1'b1 :
                       (wr_exit || sub_clr_shadow) ? 1'b0 : shadow_reg;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      shadow_reg <= 1'b0;
    end else if (clk_en) begin
      shadow_reg <= shadow_next;
    end
  end

  // Field outputs come straight from the bank flops; shadow_bank_enable comes from shadow_reg
  assign pll_eq_code        = eq_r;
  assign dao_after_conceal  = dao_r[cd_ctrl_pkg::DAO_AFTER];
  assign dao_accuracy       = {dao_r[cd_ctrl_pkg::DAO_ACC_HI],
                               dao_r[cd_ctrl_pkg::DAO_ACC_LO]};
  assign dao_flags_on       = dao_r[cd_ctrl_pkg::DAO_FLAGS];
  assign crystal_direct     = spd_r[cd_ctrl_pkg::SPD_CRYSTAL];
  assign double_speed       = spd_r[cd_ctrl_pkg::SPD_DOUBLE];
  assign op_state           = spd_r[1:0];
  assign offtrack_external  = mut_r[cd_ctrl_pkg::MUTE_OFFTRK];
  assign separate_mute      = !mut_r[cd_ctrl_pkg::MUTE_SINGLE];
  assign audio_features_en  = aud_r[cd_ctrl_pkg::AUD_FEATURE];
  assign lock_to_disc       = aud_r[cd_ctrl_pkg::AUD_LOCK];
  assign brake_six_pct      = aud_r[cd_ctrl_pkg::AUD_BRAKE];
  assign subcode_on         = sub_r[cd_ctrl_pkg::SUB_ON];
  assign subcode_three_wire = sub_r[cd_ctrl_pkg::SUB_THREE];
  assign shadow_bank_enable = shadow_reg;

  // Pin routing next values
  wire logic [1:0] p4_mode = pin_r[1:0];
  wire logic [1:0] p5_mode = pin_r[3:2];
  wire logic dao_off_next  = dao_r[cd_ctrl_pkg::DAO_ACC_HI] &&
                             dao_r[cd_ctrl_pkg::DAO_ACC_LO];
  wire logic motor_next    = (pin_r == 4'h0);
  wire logic bypass_next   = (p5_mode == cd_ctrl_pkg::PIN_ALT);
  wire logic offtrk_next   = offtrack_external ? pin1_sync :
                             internal_offtrack;
  wire logic kill_next     = separate_mute ? kill_left :
                             (kill_left || kill_right);
  wire logic pin3_next     = separate_mute ? kill_right :
                             mut_r[cd_ctrl_pkg::MUTE_PIN3];
  wire logic pin4_next     = (p4_mode == cd_ctrl_pkg::PIN_ALT)  ?
                             subcode_q_to_w :
                             (p4_mode == cd_ctrl_pkg::PIN_MOTOR) ?
                             motor_line_a :
                             (p4_mode == cd_ctrl_pkg::PIN_HIGH);
  wire logic pin5_next     = (p5_mode == cd_ctrl_pkg::PIN_ALT)  ?
                             deemph_flag :
                             (p5_mode == cd_ctrl_pkg::PIN_MOTOR) ?
                             motor_line_b :
                             (p5_mode == cd_ctrl_pkg::PIN_HIGH);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dao_off             <= 1'b0;
      motor_four_line     <= 1'b0;
      deemph_bypass       <= 1'b0;
      offtrack_signal     <= 1'b0;
      kill_out            <= 1'b0;
      versatile_pin_three <= 1'b0;
      versatile_pin_four  <= 1'b1;
      versatile_pin_five  <= 1'b1;
    end else if (clk_en) begin
      dao_off             <= dao_off_next;
      motor_four_line     <= motor_next;
      deemph_bypass       <= bypass_next;
      offtrack_signal     <= offtrk_next;
      kill_out            <= kill_next;
      versatile_pin_three <= pin3_next;
      versatile_pin_four  <= pin4_next;
      versatile_pin_five  <= pin5_next;
    end
  end

  // APB answer: zero wait states, answer registered at the setup edge
  wire logic [3:0] rd_nib = in_bank ? bank_reg[idx[3:0]] : 4'h0;
  wire logic [cd_ctrl_pkg::DATA_W-1:0] status_word = {
    27'h0, offtrack_signal, op_state, pin1_sync, shadow_reg};
  wire logic [cd_ctrl_pkg::DATA_W-1:0] rd_next =
    pwrite  ? 32'h0 :
    in_bank ? {28'h0, rd_nib} :
    is_stat ? status_word : 32'h0;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else if (clk_en) begin
      pready <= setup;
      if (setup) begin
        pslverr <= setup_err;
        prdata  <= rd_next;
      end else if (access) begin
        pslverr <= 1'b0;
        prdata  <= 32'h0;
      end
    end
  end

  // Shadow bank write strobe: one cycle per redirected write
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      shadow_wr_strobe <= 1'b0;
      shadow_wr_addr   <= 4'h0;
      shadow_wr_data   <= 4'h0;
    end else if (clk_en) begin
      shadow_wr_strobe <= wr_shad;
      if (wr_shad) begin
        shadow_wr_addr <= idx[3:0];
        shadow_wr_data <= nib;
      end
    end
  end

  // Checks
  a_reset_values: assert property (@(posedge clock) disable iff (!nrst)
    $rose(rst_n) |-> (pll_eq_code == 4'h3) && dao_after_conceal &&
      (dao_accuracy == 2'h0) && !dao_flags_on && (op_state == 2'h0) &&
      (pin_r == 4'hF) && (aud_r == 4'h4) && (sub_r == 4'h0) &&
      (mut_r == 4'h2) && !crystal_direct && !shadow_bank_enable)
    else $error("register bank not at initial values after reset");

  a_eq_legal_code: assert property (@(posedge clock) disable iff (!rst_n)
    (pll_eq_code >= 4'h1) && (pll_eq_code <= 4'h5))
    else $error("equalization register holds an undocumented code");

  a_eq_write_lands: assert property (@(posedge clock)
    disable iff (!rst_n)
    clk_en && wr_main && (idx == 6'h09) |=> (pll_eq_code == $past(nib)))
    else $error("equalization write did not land");

  a_speed_write: assert property (@(posedge clock)
    disable iff (!rst_n)
    clk_en && wr_main && (idx == 6'h0B) |=>
      (double_speed == $past(nib[3])) && (crystal_direct == $past(nib[2])))
    else $error("speed register write mismatch");

  a_op_state_legal: assert property (@(posedge clock)
    disable iff (!rst_n) op_state != 2'h1)
    else $error("operating state field holds reserved code");

  a_dao_off_low: assert property (@(posedge clock)
    disable iff (!rst_n)
    clk_en && (dao_accuracy == 2'h3) |=> dao_off)
    else $error("audio output not switched off for code 11");

  a_offtrack_src: assert property (@(posedge clock)
    disable iff (!rst_n)
    clk_en && offtrack_external |=> offtrack_signal == $past(pin1_sync))
    else $error("external off-track not taken from pin one");

  a_single_mute: assert property (@(posedge clock)
    disable iff (!rst_n)
    clk_en && !separate_mute |=>
      versatile_pin_three == $past(mut_r[2]))
    else $error("pin three not at fixed level in single mute");

  a_pin_four_low: assert property (@(posedge clock)
    disable iff (!rst_n)
    clk_en && (p4_mode == 2'h2) |=> !versatile_pin_four)
    else $error("pin four not driven low");

  a_pin_five_alt: assert property (@(posedge clock)
    disable iff (!rst_n)
    clk_en && (p5_mode == 2'h1) |=>
      deemph_bypass && (versatile_pin_five == $past(deemph_flag)))
    else $error("pin five not showing de-emphasis");

  a_shadow_redirect: assert property (@(posedge clock)
    disable iff (!rst_n)
    clk_en && access && pwrite && shadow_reg && in_bank |=>
      shadow_wr_strobe && $stable(pin_r) && $stable(aud_r))
    else $error("shadow-mode write reached the main bank");

  a_bad_code_err: assert property (@(posedge clock)
    disable iff (!rst_n)
    clk_en && setup && pwrite && bad_code |=> pready && pslverr)
    else $error("undocumented code not refused");

endmodule
`default_nettype wire

// >>> tb/apb_host_model.sv
// Host side of the register bus: one APB master issuing single transfers.
// Assumes the bench calls xfer and its watchdog cuts a missing pready short.
`timescale 1ns/1ps
`default_nettype none
module apb_host_model (
  // Clock
  input  wire logic        clock,
  // APB master
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic        pready
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // Released address and data lines show the inverse so stale values cannot pass for data
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// >>> tb/cd_decoder_control_regs_test.sv
// Self-checking bench for the decoder control register bank.
// Assumes apb_host_model as bus master; design assertions run inside.
`timescale 1ns/1ps
`default_nettype none
module cd_decoder_control_regs_test;
  logic clock, nrst, clk_en, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, pins;
  logic [31:0] pwdata, prdata;
  logic versatile_pin_one, internal_offtrack, kill_left, kill_right;
  logic subcode_q_to_w, deemph_flag, motor_line_a, motor_line_b;
  logic [3:0] pll_eq_code, shadow_wr_addr, shadow_wr_data;
  logic [1:0] dao_accuracy, op_state;
  logic dao_after_conceal, dao_off, dao_flags_on, crystal_direct;
  logic double_speed, offtrack_external, separate_mute, motor_four_line;
  logic deemph_bypass, audio_features_en, lock_to_disc, brake_six_pct;
  logic subcode_on, subcode_three_wire, shadow_bank_enable;
  logic offtrack_signal, kill_out, versatile_pin_three;
  logic versatile_pin_four, versatile_pin_five, shadow_wr_strobe;
  logic [3:0] v [9:15];
  logic [32:0] exp_q [$];
  logic [32:0] note;
  logic [15:0] seed = 16'hD932;
  logic ok;
  int err_count = 0;
  int num_checks = 0;

  assign {versatile_pin_one, internal_offtrack, kill_left, kill_right,
          subcode_q_to_w, deemph_flag, motor_line_a, motor_line_b} = pins;

  cd_decoder_control_regs cd_decoder_control_regs_i (.clock, .nrst, .clk_en,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .versatile_pin_one, .internal_offtrack, .kill_left, .kill_right,
    .subcode_q_to_w, .deemph_flag, .motor_line_a, .motor_line_b,
    .pll_eq_code, .dao_after_conceal, .dao_accuracy, .dao_off, .dao_flags_on,
    .crystal_direct, .double_speed, .op_state, .offtrack_external,
    .separate_mute, .motor_four_line, .deemph_bypass, .audio_features_en,
    .lock_to_disc, .brake_six_pct, .subcode_on, .subcode_three_wire,
    .shadow_bank_enable, .offtrack_signal, .kill_out, .versatile_pin_three,
    .versatile_pin_four, .versatile_pin_five, .shadow_wr_strobe,
    .shadow_wr_addr, .shadow_wr_data);

  apb_host_model apb_host_model_i (.clock, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready);

  initial clock = 1'b0;
  always #25 clock = ~clock;

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic pinv(input logic [1:0] f, input logic alt,
                                input logic mot);
    return (f == 2'h0) ? mot : (f == 2'h1) ? alt : f[0];
  endfunction

  // Undocumented codes that the bank must refuse
  function automatic logic legal(input int r, input logic [3:0] c);
    case (r)
      9: return (c >= 4'h1) && (c <= 4'h5);
      11: return c[1:0] != 2'h1;
      12: return !(c[1] && c[3]);
      13: return (c[1:0] == 2'h0) == (c[3:2] == 2'h0);
      14: return !c[3];
      default: return 1'b1;
    endcase
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic acc(input logic wr, input int idx, input logic [3:0] d,
                     input logic [3:0] ed, input logic ee);
    exp_q.push_back({ee, 28'h0, ed});
    apb_host_model_i.xfer(wr, 8'(idx * 4), {28'h0, d});
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic check_outs;
    chk(pll_eq_code, v[9]);
    chk(dao_after_conceal, v[10][1]);
    chk(dao_accuracy, {v[10][2], v[10][0]});
    chk(dao_off, v[10][2] & v[10][0]);
    chk(dao_flags_on, v[10][3]);
    chk(crystal_direct, v[11][2]);
    chk(double_speed, v[11][3]);
    chk(op_state, v[11][1:0]);
    chk(offtrack_external, v[12][0]);
    chk(offtrack_signal, v[12][0] ? versatile_pin_one : internal_offtrack);
    chk(separate_mute, !v[12][1]);
    chk(kill_out, v[12][1] ? (kill_left | kill_right) : kill_left);
    chk(versatile_pin_three, v[12][1] ? v[12][2] : kill_right);
    chk(motor_four_line, v[13] == 4'h0);
    chk(versatile_pin_four, pinv(v[13][1:0], subcode_q_to_w, motor_line_a));
    chk(versatile_pin_five, pinv(v[13][3:2], deemph_flag, motor_line_b));
    chk(deemph_bypass, v[13][3:2] == 2'h1);
    chk(audio_features_en, v[14][2]);
    chk(lock_to_disc, v[14][1]);
    chk(brake_six_pct, v[14][0]);
    chk(subcode_on, v[15][2]);
    chk(subcode_three_wire, v[15][3]);
    chk(shadow_bank_enable, v[15][0]);
  endtask

  task automatic do_reset;
    @(posedge clock);
    nrst <= 1'b0;
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    v = '{4'h3, 4'h2, 4'h0, 4'h2, 4'hF, 4'h4, 4'h0};
    repeat (3) @(posedge clock);
    settle(1);
    check_outs;
  endtask

  // Answer taken at the rising edge that completes the transfer
  always @(posedge clock) begin
    if (psel && penable && pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk(32'h1, 32'h0);
      end else begin
        note = exp_q.pop_front();
        chk(prdata, note[31:0]);
        chk(pslverr, note[32]);
      end
    end
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #1000000;
    err_count++;
    end_of_test;
  end

  initial begin
    nrst = 1'b0;
    clk_en = 1'b1;
    pins = 8'h00;
    do_reset;
    $display("test reset done");
    for (int r = 9; r <= 15; r++) begin
      for (int c = 0; c < 16; c += (r == 15) ? 2 : 1) begin
        ok = legal(r, 4'(c));
        if (ok) v[r] = 4'(c);
        @(posedge clock);
        seed = lfsr(seed);
        pins <= seed[7:0];
        acc(1'b1, r, 4'(c), 4'h0, !ok);
        acc(1'b0, r, 4'h0, v[r], 1'b0);
        settle(3);
        check_outs;
      end
    end
    $display("test sweep done");
    acc(1'b1, 15, 4'h5, 4'h0, 1'b0);
    v[15] = 4'h5;
    for (int k = 9; k <= 15; k++) begin
      seed = lfsr(seed);
      acc(1'b1, k, seed[3:0], 4'h0, 1'b0);
      settle(1);
      chk(shadow_wr_strobe, 32'h1);
      chk(shadow_wr_addr, k[3:0]);
      chk(shadow_wr_data, seed[3:0]);
    end
    settle(2);
    check_outs;
    acc(1'b1, 17, 4'h1, 4'h0, 1'b0);
    v[15] = 4'h4;
    settle(2);
    check_outs;
    chk(shadow_wr_strobe, 32'h0);
    $display("test shadow done");
    acc(1'b0, 0, 4'h0, 4'h0, 1'b1);
    acc(1'b1, 16, 4'hF, 4'h0, 1'b1);
    exp_q.push_back({1'b0, 27'h0,
                     (v[12][0] ? versatile_pin_one : internal_offtrack),
                     v[11][1:0], versatile_pin_one, v[15][0]});
    apb_host_model_i.xfer(1'b0, 8'h40, 32'h0);
    acc(1'b0, 17, 4'h0, 4'h0, 1'b0);
    settle(2);
    check_outs;
    $display("test errors done");
    do_reset;
    $display("test second reset done");
    end_of_test;
  end
endmodule
`default_nettype wire
